// ===== sacr_checker.sv
`timescale 1ns/1ns

// ****************************************************************
// Bus timing and field checks
// ****************************************************************
module sacr_checker
   import sacr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic adcLevelShiftEn,
   input wire logic sensor1Invert,
   input wire logic capFrontEndSel,
   input wire logic [2:0] sensor1Stage1Gain,
   input wire logic [4:0] sensor1Stage2Gain,
   input wire logic [1:0] capThreshold,
   input wire logic [2:0] capDriveCurrent,
   input wire logic [1:0] capTransZ,
   input wire logic outDacDisable,
   input wire logic anaTestMuxEn,
   input wire logic testUnlocked
);
   logic take;
   logic keyWr;
   logic wrVal_q;
   logic [7:0] wrIdx_q;

   // Accepted address phase and final unlock key in a data phase
   assign take = hsel & htrans[1] & hready;
   assign keyWr = wrVal_q && wrIdx_q == IDX_UNLOCK && hwdata[7:0] == UNLOCK_KEY_2;

   // Remember a write address phase for its data phase
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wrVal_q <= 1'b0;
         wrIdx_q <= 8'h00;
      end else begin
         wrVal_q <= take & hwrite;
         wrIdx_q <= haddr[9:2];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_write_nowait; take && hwrite |=> hreadyout; endproperty
   a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
   property p_read_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
   property p_reset_res; $rose(nrst) |-> !capFrontEndSel; endproperty
   a_reset_res: assert property (p_reset_res) else $error("front end not resistive");
   property p_cap_fields;
      wrVal_q && wrIdx_q == IDX_FE_SELECT_CAP |=>
         {capFrontEndSel, capDriveCurrent, capThreshold, capTransZ} == $past(hwdata[7:0]);
   endproperty
   a_cap_fields: assert property (p_cap_fields) else $error("cap fields wrong");
   property p_gain;
      wrVal_q && wrIdx_q == IDX_SENSOR1_GAIN |=>
         {sensor1Stage1Gain, sensor1Stage2Gain} == $past(hwdata[7:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain fields wrong");
   property p_shift_inv;
      wrVal_q && wrIdx_q == IDX_FE_CONTROL |=>
         adcLevelShiftEn == $past(hwdata[FE_LEVEL_SHIFT_BIT]) &&
         sensor1Invert == $past(hwdata[FE_INV_S1_BIT]);
   endproperty
   a_shift_inv: assert property (p_shift_inv) else $error("level shift differs");
   property p_hold;
      !wrVal_q |=> $stable({capFrontEndSel, capDriveCurrent, capThreshold, capTransZ});
   endproperty
   a_hold: assert property (p_hold) else $error("cap fields moved");
   property p_locked;
      wrVal_q && wrIdx_q == IDX_ANA_TEST_ENABLE && !testUnlocked |=>
         $stable({outDacDisable, anaTestMuxEn});
   endproperty
   a_locked: assert property (p_locked) else $error("locked write took effect");
   property p_unlocked;
      wrVal_q && wrIdx_q == IDX_ANA_TEST_ENABLE && testUnlocked |=>
         {anaTestMuxEn, outDacDisable} == $past(hwdata[4:3]);
   endproperty
   a_unlocked: assert property (p_unlocked) else $error("test enable wrong");
   property p_unlock_seq; $rose(testUnlocked) |-> $past(keyWr); endproperty
   a_unlock_seq: assert property (p_unlock_seq) else $error("unlock without key");

   cover property (take && !hwrite);
   cover property ($rose(testUnlocked));
   cover property ($rose(capFrontEndSel));
endmodule : sacr_checker

bind sacr_regs sacr_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .adcLevelShiftEn(adcLevelShiftEn), .sensor1Invert(sensor1Invert),
   .capFrontEndSel(capFrontEndSel), .sensor1Stage1Gain(sensor1Stage1Gain),
   .sensor1Stage2Gain(sensor1Stage2Gain), .capThreshold(capThreshold),
   .capDriveCurrent(capDriveCurrent), .capTransZ(capTransZ), .outDacDisable(outDacDisable),
   .anaTestMuxEn(anaTestMuxEn), .testUnlocked(testUnlocked));

// ===== sacr_pkg.sv
package sacr_pkg;

   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] IDX_DIG_TEST_ENABLE = 8'h03;
   localparam logic [7:0] IDX_OUT_TEST_ROUTE = 8'h06;
   localparam logic [7:0] IDX_DIG_TEST_IN_ROUTE = 8'h07;
   localparam logic [7:0] IDX_ANA_TEST_IN_ROUTE = 8'h08;
   localparam logic [7:0] IDX_ANA_TEST_ENABLE = 8'h10;
   localparam logic [7:0] IDX_UNLOCK = 8'hff;
   localparam logic [7:0] IDX_SUPPLY_FLAGS_A = 8'h91;
   localparam logic [7:0] IDX_SUPPLY_FLAGS_B = 8'h92;
   localparam logic [7:0] IDX_FE_DIAG_FLAGS = 8'h93;
   localparam logic [7:0] IDX_SENSOR1_GAIN = 8'ha1;
   localparam logic [7:0] IDX_SENSOR2_GAIN = 8'ha2;
   localparam logic [7:0] IDX_SENSOR1_OFS_LO = 8'ha3;
   localparam logic [7:0] IDX_SENSOR1_OFS_HI = 8'ha4;
   localparam logic [7:0] IDX_SENSOR2_OFS_LO = 8'ha5;
   localparam logic [7:0] IDX_SENSOR2_OFS_HI = 8'ha6;
   localparam logic [7:0] IDX_FE_SELECT_CAP = 8'ha7;
   localparam logic [7:0] IDX_FE_CONTROL = 8'ha9;
   localparam logic [7:0] IDX_ADC_DEC_SELECT = 8'hb3;
   localparam logic [7:0] IDX_ADC_UPDATE = 8'hb4;
   localparam logic [7:0] IDX_ADC_RESULT_0 = 8'he0;
   localparam logic [7:0] IDX_ADC_RESULT_1 = 8'he1;
   localparam logic [7:0] IDX_ADC_RESULT_2 = 8'he2;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int DEC_SEL_LSB = 0;
   localparam int DEC_SEL_W = 3;
   localparam int FE_SENSOR_SEL_BIT = 7;
   localparam int FE_INV_S2_BIT = 6;
   localparam int FE_INV_S1_BIT = 5;
   localparam int FE_LEVEL_SHIFT_BIT = 5;
   localparam int FE_TEMP_SENSOR_BIT = 4;
   localparam int FE_BRIDGE_REG_BIT = 2;
   localparam int CAP_FE_SELECT_BIT = 7;
   localparam int CAP_CURRENT_LSB = 4;
   localparam int CAP_CURRENT_W = 3;
   localparam int CAP_THRESH_LSB = 2;
   localparam int CAP_THRESH_W = 2;
   localparam int CAP_TRANSZ_LSB = 0;
   localparam int CAP_TRANSZ_W = 2;
   localparam int GAIN1_LSB = 5;
   localparam int GAIN1_W = 3;
   localparam int GAIN2_LSB = 0;
   localparam int GAIN2_W = 5;
   localparam int ZTC_HI_W = 2;
   localparam int TEMP_PROPORTIONAL_OFFSET_LSB = 2;
   localparam int TEMP_PROPORTIONAL_OFFSET_W = 6;
   localparam int ANA_DAC_OFF_BIT = 3;
   localparam int ANA_MUX_EN_BIT = 4;
   localparam int DIG_IN_CTRL_BIT = 1;
   localparam int DIG_OUT_EN_LSB = 2;
   localparam int DIG_OUT_EN_W = 2;
   localparam int ADC_UPDATE_BIT = 0;
   localparam int UNLOCK_STATE_BIT = 0;

   // ****************************************************************
   // Reset values and unlock keys
   // ****************************************************************
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic CAP_FE_RESISTIVE = 1'b0;
   localparam logic [7:0] UNLOCK_KEY_1 = 8'h5a;
   localparam logic [7:0] UNLOCK_KEY_2 = 8'ha5;

   // ****************************************************************
   // Decimator defaults
   // ****************************************************************
   localparam int NUM_DEC_DEF = 8;
   localparam int DEC_W_DEF = 24;
   localparam int RESULT_W = 24;

   typedef enum logic [1:0] {
      LOCKED,
      KEY1_SEEN,
      UNLOCKED
   } sacr_lock_t;

endpackage : sacr_pkg

// ===== sacr_regs.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns

// Summary of operation
// - Update request copies decimator output to shadow
// - Register 0xB3 bits 0-2 pick decimator
// - 0xA9 bit 5 enables ADC level shift
// - 0xA9 bit 4 selects internal temperature sensor
// - 0xA7 bit 7 picks resistive or capacitive
// - Front end resets to resistive
// - 0xA9 bit 2 enables bridge drive regulator
// - 0xA9 bit 7 picks sensor input pair
// - 0xA9 bits 5/6 invert sensor sign
// - 0xA1/0xA2 bits 5-7 hold stage-one gain
// - 0xA1/0xA2 bits 0-4 hold stage-two gain
// - 0xA7 bits 2-3 set comparator threshold
// - 0xA7 bits 4-6 set capacitive drive current
// - 0xA7 bits 0-1 set transimpedance
// - Zero-tempco offset spans register pair, read/write
// - Temperature offset shares upper offset register
// - Front-end diagnostic flags read at 0x93
// - Supply monitor flags read at 0x91/0x92
// - 0x10 bits 3-4 disable DACs, enable muxes
// - Test mux writes ignored while locked
// - 0x08 and 0x06 route analog test signals
// - 0x03 bit 1 input, bits 2-3 output
// - 0x07 routes digital test inputs
// - Key sequence at 0xFF unlocks test space
module sacr_regs
   import sacr_pkg::*;
#(
   parameter int NUM_DEC = NUM_DEC_DEF,
   parameter int DEC_W = DEC_W_DEF
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_DEC*DEC_W-1:0] decimOut,
   input wire logic [7:0] supplyMonitorFlagsA,
   input wire logic [7:0] supplyMonitorFlagsB,
   input wire logic [7:0] frontEndDiagFlags,
   output logic adcLevelShiftEn,
   output logic tempSensorSel,
   output logic capFrontEndSel,
   output logic bridgeDriveRegEn,
   output logic sensorPairSel,
   output logic sensor1Invert,
   output logic sensor2Invert,
   output logic [2:0] sensor1Stage1Gain,
   output logic [4:0] sensor1Stage2Gain,
   output logic [2:0] sensor2Stage1Gain,
   output logic [4:0] sensor2Stage2Gain,
   output logic [1:0] capThreshold,
   output logic [2:0] capDriveCurrent,
   output logic [1:0] capTransZ,
   output logic [9:0] sensor1ZeroTempcoOffset,
   output logic [5:0] sensor1TempPropOffset,
   output logic [9:0] sensor2ZeroTempcoOffset,
   output logic [5:0] sensor2TempPropOffset,
   output logic outDacDisable,
   output logic anaTestMuxEn,
   output logic [7:0] anaTestInRoute,
   output logic [7:0] outTestRoute,
   output logic digTestInCtrl,
   output logic [1:0] digTestOutEn,
   output logic [7:0] digTestInRoute,
   output logic testUnlocked
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (NUM_DEC < 1 || NUM_DEC > 8) begin : g_bad_num_dec
      $error("NUM_DEC must lie in 1..8");
   end
   if (DEC_W < 1 || DEC_W > RESULT_W) begin : g_bad_dec_w
      $error("DEC_W must lie in 1..24");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic wrPend;
      logic rdPend;
      logic rdWait;
      logic [7:0] addrIdx;
      logic [31:0] rdData;
      sacr_lock_t lock;
      logic [7:0] digTestEnable;
      logic [7:0] outTestRoute;
      logic [7:0] digTestInRoute;
      logic [7:0] anaTestInRoute;
      logic [7:0] anaTestEnable;
      logic [7:0] sensor1Gain;
      logic [7:0] sensor2Gain;
      logic [7:0] sensor1OfsLo;
      logic [7:0] sensor1OfsHi;
      logic [7:0] sensor2OfsLo;
      logic [7:0] sensor2OfsHi;
      logic [7:0] feSelectCap;
      logic [7:0] feControl;
      logic [7:0] adcDecSelect;
      logic [RESULT_W-1:0] adcShadow;
   } sacr_state_t;

   sacr_state_t state_q;
   sacr_state_t state_d;

   logic [7:0] supFlagsA;
   logic [7:0] supFlagsB;
   logic [7:0] diagFlags;

   // Analog flag sources come from outside the clock domain
   sacr_sync #(
      .W(24)
   ) u_flag_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .asyncIn({supplyMonitorFlagsA, supplyMonitorFlagsB, frontEndDiagFlags}),
      .syncOut({supFlagsA, supFlagsB, diagFlags})
   );

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // Restricted test mux registers
   function automatic logic isTestMux(input logic [7:0] idx);
      isTestMux = (idx == IDX_DIG_TEST_ENABLE) || (idx == IDX_OUT_TEST_ROUTE) ||
                  (idx == IDX_DIG_TEST_IN_ROUTE) || (idx == IDX_ANA_TEST_IN_ROUTE) ||
                  (idx == IDX_ANA_TEST_ENABLE);
   endfunction : isTestMux

   // Chosen decimator word, zero-extended to result width
   function automatic logic [RESULT_W-1:0] pickDecim(input logic [2:0] sel,
                                                     input logic [NUM_DEC*DEC_W-1:0] all);
      logic [RESULT_W-1:0] res;
      res = '0;
      for (int i = 0; i < NUM_DEC; i++) begin
         if (sel == i[2:0]) begin
            res[DEC_W-1:0] = all[i*DEC_W +: DEC_W];
         end
      end
      pickDecim = res;
   endfunction : pickDecim

   // Register read mux
   function automatic logic [7:0] readReg(input logic [7:0] idx, input sacr_state_t s,
                                          input logic [7:0] fa, input logic [7:0] fb,
                                          input logic [7:0] fd);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         IDX_DIG_TEST_ENABLE: v = s.digTestEnable;
         IDX_OUT_TEST_ROUTE: v = s.outTestRoute;
         IDX_DIG_TEST_IN_ROUTE: v = s.digTestInRoute;
         IDX_ANA_TEST_IN_ROUTE: v = s.anaTestInRoute;
         IDX_ANA_TEST_ENABLE: v = s.anaTestEnable;
         IDX_UNLOCK: v[UNLOCK_STATE_BIT] = (s.lock == UNLOCKED);
         IDX_SUPPLY_FLAGS_A: v = fa;
         IDX_SUPPLY_FLAGS_B: v = fb;
         IDX_FE_DIAG_FLAGS: v = fd;
         IDX_SENSOR1_GAIN: v = s.sensor1Gain;
         IDX_SENSOR2_GAIN: v = s.sensor2Gain;
         IDX_SENSOR1_OFS_LO: v = s.sensor1OfsLo;
         IDX_SENSOR1_OFS_HI: v = s.sensor1OfsHi;
         IDX_SENSOR2_OFS_LO: v = s.sensor2OfsLo;
         IDX_SENSOR2_OFS_HI: v = s.sensor2OfsHi;
         IDX_FE_SELECT_CAP: v = s.feSelectCap;
         IDX_FE_CONTROL: v = s.feControl;
         IDX_ADC_DEC_SELECT: v = s.adcDecSelect;
         IDX_ADC_RESULT_0: v = s.adcShadow[7:0];
         IDX_ADC_RESULT_1: v = s.adcShadow[15:8];
         IDX_ADC_RESULT_2: v = s.adcShadow[23:16];
         default: v = 8'h00;
      endcase
      readReg = v;
   endfunction : readReg

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   logic addrPhase;
   logic [7:0] wByte;

   assign addrPhase = hsel && htrans[1] && hready;
   assign wByte = hwdata[7:0];

   always_comb begin
      state_d = state_q;
      state_d.wrPend = 1'b0;
      state_d.rdPend = 1'b0;
      state_d.rdWait = 1'b0;

      // Read wait state: load data one cycle into the data phase
      if (state_q.rdPend) begin
         state_d.rdData = {24'h000000,
                           readReg(state_q.addrIdx, state_q, supFlagsA, supFlagsB, diagFlags)};
         state_d.rdWait = 1'b1;
      end

      if (state_q.wrPend) begin
         case (state_q.addrIdx)
            IDX_SENSOR1_GAIN: state_d.sensor1Gain = wByte;
            IDX_SENSOR2_GAIN: state_d.sensor2Gain = wByte;
            IDX_SENSOR1_OFS_LO: state_d.sensor1OfsLo = wByte;
            IDX_SENSOR1_OFS_HI: state_d.sensor1OfsHi = wByte;
            IDX_SENSOR2_OFS_LO: state_d.sensor2OfsLo = wByte;
            IDX_SENSOR2_OFS_HI: state_d.sensor2OfsHi = wByte;
            IDX_FE_SELECT_CAP: state_d.feSelectCap = wByte;
            IDX_FE_CONTROL: state_d.feControl = wByte;
            IDX_ADC_DEC_SELECT: state_d.adcDecSelect = wByte;
            IDX_ADC_UPDATE: begin
               if (wByte[ADC_UPDATE_BIT]) begin
                  state_d.adcShadow = pickDecim(
                     state_q.adcDecSelect[DEC_SEL_LSB +: DEC_SEL_W], decimOut);
               end
            end
            IDX_UNLOCK: begin
               if (wByte == UNLOCK_KEY_1) begin
                  state_d.lock = KEY1_SEEN;
               end else if (wByte == UNLOCK_KEY_2 && state_q.lock == KEY1_SEEN) begin
                  state_d.lock = UNLOCKED;
               end else begin
                  state_d.lock = LOCKED;
               end
            end
            default: begin
            end
         endcase

         if (isTestMux(state_q.addrIdx) && state_q.lock == UNLOCKED) begin
            case (state_q.addrIdx)
               IDX_DIG_TEST_ENABLE: state_d.digTestEnable = wByte;
               IDX_OUT_TEST_ROUTE: state_d.outTestRoute = wByte;
               IDX_DIG_TEST_IN_ROUTE: state_d.digTestInRoute = wByte;
               IDX_ANA_TEST_IN_ROUTE: state_d.anaTestInRoute = wByte;
               IDX_ANA_TEST_ENABLE: state_d.anaTestEnable = wByte;
               default: begin
               end
            endcase
         end
      end

      // Capture a new address phase
      if (addrPhase) begin
         state_d.addrIdx = haddr[9:2];
         state_d.wrPend = hwrite;
         state_d.rdPend = !hwrite;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_q <= '0;
         state_q.lock <= LOCKED;
         state_q.digTestEnable <= RST_REG;
         state_q.outTestRoute <= RST_REG;
         state_q.digTestInRoute <= RST_REG;
         state_q.anaTestInRoute <= RST_REG;
         state_q.anaTestEnable <= RST_REG;
         state_q.sensor1Gain <= RST_REG;
         state_q.sensor2Gain <= RST_REG;
         state_q.sensor1OfsLo <= RST_REG;
         state_q.sensor1OfsHi <= RST_REG;
         state_q.sensor2OfsLo <= RST_REG;
         state_q.sensor2OfsHi <= RST_REG;
         state_q.feSelectCap <= {CAP_FE_RESISTIVE, 7'h00};
         state_q.feControl <= RST_REG;
         state_q.adcDecSelect <= RST_REG;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Bus outputs
   // ****************************************************************
   // Reads stretch by one wait state, writes have none
   assign hreadyout = !state_q.rdPend;
   assign hresp = 1'b0;
   assign hrdata = state_q.rdData;

   // ****************************************************************
   // Front-end control outputs
   // ****************************************************************
   // level shift enable
   assign adcLevelShiftEn = state_q.feControl[FE_LEVEL_SHIFT_BIT];
   assign tempSensorSel = state_q.feControl[FE_TEMP_SENSOR_BIT];
   assign bridgeDriveRegEn = state_q.feControl[FE_BRIDGE_REG_BIT];
   assign sensorPairSel = state_q.feControl[FE_SENSOR_SEL_BIT];
   assign sensor1Invert = state_q.feControl[FE_INV_S1_BIT];
   assign sensor2Invert = state_q.feControl[FE_INV_S2_BIT];

   assign capFrontEndSel = state_q.feSelectCap[CAP_FE_SELECT_BIT];
   assign capThreshold = state_q.feSelectCap[CAP_THRESH_LSB +: CAP_THRESH_W];
   assign capDriveCurrent = state_q.feSelectCap[CAP_CURRENT_LSB +: CAP_CURRENT_W];
   assign capTransZ = state_q.feSelectCap[CAP_TRANSZ_LSB +: CAP_TRANSZ_W];

   assign sensor1Stage1Gain = state_q.sensor1Gain[GAIN1_LSB +: GAIN1_W];
   assign sensor2Stage1Gain = state_q.sensor2Gain[GAIN1_LSB +: GAIN1_W];
   assign sensor1Stage2Gain = state_q.sensor1Gain[GAIN2_LSB +: GAIN2_W];
   assign sensor2Stage2Gain = state_q.sensor2Gain[GAIN2_LSB +: GAIN2_W];

   assign sensor1ZeroTempcoOffset = {state_q.sensor1OfsHi[ZTC_HI_W-1:0], state_q.sensor1OfsLo};
   assign sensor2ZeroTempcoOffset = {state_q.sensor2OfsHi[ZTC_HI_W-1:0], state_q.sensor2OfsLo};
   assign sensor1TempPropOffset = state_q.sensor1OfsHi[TEMP_PROPORTIONAL_OFFSET_LSB +: TEMP_PROPORTIONAL_OFFSET_W];
   assign sensor2TempPropOffset = state_q.sensor2OfsHi[TEMP_PROPORTIONAL_OFFSET_LSB +: TEMP_PROPORTIONAL_OFFSET_W];

   // ****************************************************************
   // Test mux outputs
   // ****************************************************************
   // DAC off, mux on
   assign outDacDisable = state_q.anaTestEnable[ANA_DAC_OFF_BIT];
   assign anaTestMuxEn = state_q.anaTestEnable[ANA_MUX_EN_BIT];
   assign anaTestInRoute = state_q.anaTestInRoute;
   assign outTestRoute = state_q.outTestRoute;
   assign digTestInCtrl = state_q.digTestEnable[DIG_IN_CTRL_BIT];
   assign digTestOutEn = state_q.digTestEnable[DIG_OUT_EN_LSB +: DIG_OUT_EN_W];
   assign digTestInRoute = state_q.digTestInRoute;
   assign testUnlocked = (state_q.lock == UNLOCKED);

endmodule : sacr_regs

// ===== sacr_sync.sv
`timescale 1ns/1ns

module sacr_sync #(
   parameter int W = 8
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sacr_sync_t;

   sacr_sync_t state_q;
   sacr_sync_t state_d;

   // Two-stage chain; only stage2 is read outside
   always_comb begin
      state_d.stage1 = asyncIn;
      state_d.stage2 = state_q.stage1;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stage2;

endmodule : sacr_sync

// ===== sensor_afe_config_regs_test.sv
`timescale 1ns/1ns

module sensor_afe_config_regs_test
   import sacr_pkg::*;
;
   logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, rdyS;
   logic [31:0] haddr, hwdata, hrdata, rdS, rd;
   logic [1:0] htrans, capThreshold, capTransZ, digTestOutEn;
   logic [2:0] hsize, sensor1Stage1Gain, sensor2Stage1Gain, capDriveCurrent;
   logic [4:0] sensor1Stage2Gain, sensor2Stage2Gain;
   logic [9:0] sensor1ZeroTempcoOffset, sensor2ZeroTempcoOffset;
   logic [5:0] sensor1TempPropOffset, sensor2TempPropOffset;
   logic [7:0] flagA, flagB, flagD, anaTestInRoute, outTestRoute, digTestInRoute, ix;
   logic adcLevelShiftEn, tempSensorSel, capFrontEndSel, bridgeDriveRegEn, sensorPairSel;
   logic sensor1Invert, sensor2Invert, outDacDisable, anaTestMuxEn, digTestInCtrl, testUnlocked;
   logic [191:0] decimOut;
   logic [7:0] mdl [256];
   logic [23:0] shadow;
   logic key1, unl;
   int errCount, checks;
   localparam logic [7:0] TAB [20] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h10, 8'h91, 8'h92,
      8'h93, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'hb3, 8'he0, 8'h00};

   sacr_regs #(.NUM_DEC(8), .DEC_W(24)) uut (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .decimOut,
      .supplyMonitorFlagsA(flagA), .supplyMonitorFlagsB(flagB), .frontEndDiagFlags(flagD),
      .adcLevelShiftEn, .tempSensorSel, .capFrontEndSel, .bridgeDriveRegEn, .sensorPairSel,
      .sensor1Invert, .sensor2Invert, .sensor1Stage1Gain, .sensor1Stage2Gain,
      .sensor2Stage1Gain, .sensor2Stage2Gain, .capThreshold, .capDriveCurrent, .capTransZ,
      .sensor1ZeroTempcoOffset, .sensor1TempPropOffset, .sensor2ZeroTempcoOffset,
      .sensor2TempPropOffset, .outDacDisable, .anaTestMuxEn, .anaTestInRoute, .outTestRoute,
      .digTestInCtrl, .digTestOutEn, .digTestInRoute, .testUnlocked);

   // Clock and settled bus values seen ahead of each rising edge
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      rdyS = hreadyout;
      rdS = hrdata;
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task results;
      if (errCount == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   // One single transfer: address phase, then data phase
   task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      do begin @(posedge clk_sys); end while (rdyS !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do begin @(posedge clk_sys); end while (rdyS !== 1'b1);
      rd = rdS;
      hsel <= 1'b0;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : xfer

   // Write through the bus and into the reference model
   task wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
      case (idx)
         IDX_UNLOCK: begin
            unl = key1 && d == UNLOCK_KEY_2;
            key1 = d == UNLOCK_KEY_1;
         end
         8'h03, 8'h06, 8'h07, 8'h08, 8'h10: if (unl) mdl[idx] = d;
         IDX_ADC_UPDATE: if (d[0]) shadow = decimOut[mdl[IDX_ADC_DEC_SELECT][2:0]*24 +: 24];
         8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9, 8'hb3: mdl[idx] = d;
         default: ;
      endcase
   endtask : wr

   // Read through the bus and compare with the model
   task rdchk(input logic [7:0] idx);
      logic [7:0] e;
      case (idx)
         IDX_SUPPLY_FLAGS_A: e = flagA;
         IDX_SUPPLY_FLAGS_B: e = flagB;
         IDX_FE_DIAG_FLAGS: e = flagD;
         IDX_UNLOCK: e = {7'h0, unl};
         IDX_ADC_RESULT_0: e = shadow[7:0];
         IDX_ADC_RESULT_1: e = shadow[15:8];
         IDX_ADC_RESULT_2: e = shadow[23:16];
         default: e = mdl[idx];
      endcase
      xfer(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), {24'h0, e}, rd);
   endtask : rdchk

   // Every field output against the model
   task outs;
      chk("feCtrl", {mdl[8'ha9][7:5], mdl[8'ha9][5:4], mdl[8'ha9][2]}, {sensorPairSel,
         sensor2Invert, sensor1Invert, adcLevelShiftEn, tempSensorSel, bridgeDriveRegEn});
      chk("capSel", mdl[8'ha7], {capFrontEndSel, capDriveCurrent, capThreshold, capTransZ});
      chk("gain1", mdl[8'ha1], {sensor1Stage1Gain, sensor1Stage2Gain});
      chk("gain2", mdl[8'ha2], {sensor2Stage1Gain, sensor2Stage2Gain});
      chk("ofs1", {mdl[8'ha4], mdl[8'ha3]}, {sensor1TempPropOffset, sensor1ZeroTempcoOffset});
      chk("ofs2", {mdl[8'ha6], mdl[8'ha5]}, {sensor2TempPropOffset, sensor2ZeroTempcoOffset});
      chk("anaTest", {mdl[8'h10][4:3], mdl[8'h08], mdl[8'h06]},
         {anaTestMuxEn, outDacDisable, anaTestInRoute, outTestRoute});
      chk("digTest", {mdl[8'h03][3:1], mdl[8'h07]}, {digTestOutEn, digTestInCtrl, digTestInRoute});
      chk("unlocked", unl, testUnlocked);
   endtask : outs

   task clrModel;
      foreach (mdl[i]) mdl[i] = 8'h00;
      shadow = 24'h0;
      key1 = 1'b0;
      unl = 1'b0;
   endtask : clrModel

   // Main sequence
   initial begin
      void'($urandom(32'hf3c59a8c));
      {nrst, hsel, hwrite, htrans, haddr, hwdata, decimOut} = '0;
      {flagA, flagB, flagD} = '0;
      hsize = 3'b010;
      errCount = 0;
      checks = 0;
      clrModel;
      @(posedge clk_sys);
      {flagA, flagB, flagD} <= 24'($urandom);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      outs;
      for (int p = 0; p < 3; p++) begin
         if (p == 1) begin
            wr(IDX_UNLOCK, UNLOCK_KEY_1);
            wr(IDX_SENSOR1_GAIN, 8'h3c);
            wr(IDX_UNLOCK, UNLOCK_KEY_2);
            rdchk(IDX_UNLOCK);
         end
         if (p == 2) wr(IDX_UNLOCK, 8'h00);
         for (int k = 0; k < 40; k++) begin
            ix = TAB[$urandom_range(19)];
            wr(ix, 8'($urandom));
            rdchk(ix);
            outs;
         end
      end
      for (int s = 0; s < 8; s++) begin
         decimOut <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
         wr(IDX_ADC_DEC_SELECT, 8'(s));
         wr(IDX_ADC_UPDATE, 8'h01);
         decimOut <= ~decimOut;
         wr(IDX_ADC_UPDATE, 8'h00);
         for (int b = 0; b < 3; b++) rdchk(8'(IDX_ADC_RESULT_0 + b));
      end
      nrst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      clrModel;
      outs;
      rdchk(IDX_ADC_RESULT_0);
      results;
   end

   // Watchdog against a hung handshake
   initial begin
      #3000000;
      errCount++;
      results;
   end
endmodule : sensor_afe_config_regs_test
